// [src/ocx_pkg.sv]
// Package: register map, field positions and types for the oscillator configuration block
package ocx_pkg;
    // Register word indices: each register is one aligned word at byte address index times four
    localparam logic [11:0] OCX_OSC_CFG_ADDR = 12'h2fa;
    localparam logic [11:0] OCX_TC_TRIM_ADDR = 12'h2f8;
    localparam logic [11:0] OCX_CTRL_ADDR = 12'h300;
    localparam logic [11:0] OCX_STAT_ADDR = 12'h304;
    localparam int OCX_BIT_EXT_OSC_ENABLE = 7;
    localparam int OCX_BIT_WIDE = 6;
    localparam int OCX_BIT_PINRES = 5;
    localparam int OCX_BIT_LOCK = 0;
    localparam int OCX_BIT_STABLE = 1;
    localparam int OCX_BIT_WRITE_LOCK_FLAG = 0;
    localparam int OCX_BIT_PLL_CLOCK_SELECT = 1;
    localparam logic [7:0] OCX_OSC_CFG_RESET = 8'h00;
    localparam logic [4:0] OCX_TC_TRIM_RESET = 5'h00;
    localparam logic [1:0] OCX_CTRL_RESET = 2'h0;

    typedef struct packed {
        logic       ext_osc_enable;
        logic       edge_filter_wide;
        logic       osc_pin_reserve;
        logic [4:0] osc_edge_filter_field;
    } ocx_osc_cfg_t;

    typedef struct packed {
        logic       active;
        logic       negative;
        logic [3:0] magnitude;
    } ocx_tc_ctrl_t;
endpackage

// [src/ocx_tc_decode.sv]
// Decoder of the temperature-coefficient trim code into analog controls
`timescale 1ns/1ps
`default_nettype none
module ocx_tc_decode
    import ocx_pkg::*;
(
    input wire logic [4:0] code,
    output var ocx_tc_ctrl_t ctrl
);
    // Top bit is direction, low four bits magnitude; zero magnitude switches compensation off
    always_comb begin
        ctrl.magnitude = code[3:0];
        ctrl.active = (code[3:0] != 4'h0);
        ctrl.negative = ~code[4] & ctrl.active;
    end
endmodule // ocx_tc_decode
`default_nettype wire

// [src/ocx_osc_cfg.sv]
// Oscillator configuration register, TC trim field and APB slave
//
// How it works
// - Trim codes 00000 and 10000 switch temperature compensation off.
// - Trim top bit is direction; larger low bits mean larger variation.
// - Config register readable always; writes need lock clear and PLL select set.
// - An accepted config write clears PLL lock and oscillator-stable status, except a flag whose input rises in that cycle.
// - Bit 7 enables external oscillator and clock monitor; clear uses internal reference.
// - Bit 6 clear gives one VCO cycle window, set gives three.
// - Bit 5 is read-only, set once oscillator enabled, cleared only by reset.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ocx_osc_cfg
    import ocx_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PLL_LOCK_IN,
    input wire logic OSC_STABLE_IN,
    output logic EXT_OSC_ENABLE,
    output logic CLK_MON_ENABLE,
    output logic REF_SEL_EXT,
    output logic EDGE_FILTER_WIDE,
    output logic [4:0] OSC_EDGE_FILTER_FIELD,
    output logic OSC_PIN_RESERVE,
    output logic [4:0] TC_COMP_TRIM,
    output logic TC_COMP_ACTIVE,
    output logic TC_COMP_NEGATIVE,
    output logic [3:0] TC_COMP_MAG,
    output logic LOCK_CLEAR,
    output logic PLL_LOCK,
    output logic OSC_STABLE_FLAG
);
    ocx_osc_cfg_t cfg;
    logic [4:0] tc_trim;
    logic write_lock_flag;
    logic pll_clock_select;
    logic lock_sync1, lock_sync2;
    logic stab_sync1, stab_sync2;
    logic lock_prev, stab_prev;
    logic pll_lock, osc_stable_flag;
    logic access, wr, known;
    logic cfg_wr_ok, trim_wr_ok;
    ocx_tc_ctrl_t tc_ctrl;

    // Word indices of the registers; software reaches each at four times its index
    localparam logic [11:0] OSC_CFG_A = OCX_OSC_CFG_ADDR;
    localparam logic [11:0] TC_A = OCX_TC_TRIM_ADDR;
    localparam logic [11:0] CTRL_A = OCX_CTRL_ADDR;
    localparam logic [11:0] STAT_A = OCX_STAT_ADDR;

    // Word match of a byte address against an index; neighbouring indices never alias
    function automatic logic hit(input logic [11:0] a, input logic [11:0] base);
        hit = (a[11:2] == base[9:0]);
    endfunction

    // Access phase takes two cycles with one wait state, so PREADY is only the registered strobe
    assign access = PSEL & PENABLE;
    assign wr = access & PWRITE & ~PREADY;
    assign known = hit(PADDR, OSC_CFG_A) | hit(PADDR, TC_A) | hit(PADDR, CTRL_A)
                 | hit(PADDR, STAT_A);
    assign cfg_wr_ok = wr & hit(PADDR, OSC_CFG_A) & PSTRB[0]
                     & ~write_lock_flag & pll_clock_select;
    assign trim_wr_ok = wr & hit(PADDR, TC_A) & PSTRB[0] & ~write_lock_flag;

    // Configuration fields; ignored writes leave them untouched
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            cfg <= OCX_OSC_CFG_RESET;
        end else begin
            if (cfg_wr_ok) begin
                cfg.ext_osc_enable <= PWDATA[OCX_BIT_EXT_OSC_ENABLE];
                cfg.edge_filter_wide <= PWDATA[OCX_BIT_WIDE];
                cfg.osc_edge_filter_field <= PWDATA[4:0];
            end
            // Sticky pin reservation: software cannot release pins once claimed
            if (cfg.ext_osc_enable) begin
                cfg.osc_pin_reserve <= 1'b1;
            end
        end
    end

    // TC trim, writable whenever the lock flag is clear
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            tc_trim <= OCX_TC_TRIM_RESET;
        end else if (trim_wr_ok) begin
            tc_trim <= PWDATA[15:11];
        end
    end

    // Own control register holding the lock flag and PLL select
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            write_lock_flag <= OCX_CTRL_RESET[OCX_BIT_WRITE_LOCK_FLAG];
            pll_clock_select <= OCX_CTRL_RESET[OCX_BIT_PLL_CLOCK_SELECT];
        end else if (wr & hit(PADDR, CTRL_A) & PSTRB[0]) begin
            write_lock_flag <= PWDATA[OCX_BIT_WRITE_LOCK_FLAG];
            pll_clock_select <= PWDATA[OCX_BIT_PLL_CLOCK_SELECT];
        end
    end

    // Status inputs come from the analog side, so synchronise them first
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            lock_sync1 <= 1'b0;
            lock_sync2 <= 1'b0;
            stab_sync1 <= 1'b0;
            stab_sync2 <= 1'b0;
            lock_prev <= 1'b0;
            stab_prev <= 1'b0;
        end else begin
            lock_sync1 <= PLL_LOCK_IN;
            lock_sync2 <= lock_sync1;
            stab_sync1 <= OSC_STABLE_IN;
            stab_sync2 <= stab_sync1;
            lock_prev <= lock_sync2;
            stab_prev <= stab_sync2;
        end
    end

    // Status flags: cleared by an accepted config write or a low input, set again on a fresh rising status
    // Set wins over clear, so a lock arriving in the write cycle is not lost
    // Limitation: after a clear, a flag returns only on a fresh rise of its input
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pll_lock <= 1'b0;
            osc_stable_flag <= 1'b0;
        end else begin
            if (lock_sync2 & ~lock_prev) begin
                pll_lock <= 1'b1;
            end else if (cfg_wr_ok) begin
                pll_lock <= 1'b0;
            end else if (~lock_sync2) begin
                pll_lock <= 1'b0;
            end
            if (stab_sync2 & ~stab_prev) begin
                osc_stable_flag <= 1'b1;
            end else if (cfg_wr_ok) begin
                osc_stable_flag <= 1'b0;
            end else if (~stab_sync2) begin
                osc_stable_flag <= 1'b0;
            end
        end
    end

    // Trim decode kept apart so the analog mapping can change on its own
    ocx_tc_decode u_tc (
        .code(tc_trim),
        .ctrl(tc_ctrl)
    );

    // APB answer: one wait state per access, error on unmapped address
    // Reads have no side effects, so software may read any register at any time
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0;
        end else begin
            PREADY <= access & ~PREADY;
            PSLVERR <= access & ~PREADY & ~known;
            PRDATA <= 32'h0;
            if (access & ~PREADY & ~PWRITE) begin
                if (hit(PADDR, OSC_CFG_A)) begin
                    PRDATA <= {24'h0, cfg};
                end else if (hit(PADDR, TC_A)) begin
                    PRDATA <= {16'h0, tc_trim, 11'h0};
                end else if (hit(PADDR, CTRL_A)) begin
                    PRDATA <= {30'h0, pll_clock_select, write_lock_flag};
                end else if (hit(PADDR, STAT_A)) begin
                    PRDATA <= {30'h0, osc_stable_flag, pll_lock};
                end
            end
        end
    end

    // Registered outputs toward oscillator, PLL and trim circuit
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            EXT_OSC_ENABLE <= 1'b0;
            CLK_MON_ENABLE <= 1'b0;
            REF_SEL_EXT <= 1'b0;
            EDGE_FILTER_WIDE <= 1'b0;
            OSC_EDGE_FILTER_FIELD <= 5'h00;
            OSC_PIN_RESERVE <= 1'b0;
            TC_COMP_TRIM <= 5'h00;
            TC_COMP_ACTIVE <= 1'b0;
            TC_COMP_NEGATIVE <= 1'b0;
            TC_COMP_MAG <= 4'h0;
            LOCK_CLEAR <= 1'b0;
            PLL_LOCK <= 1'b0;
            OSC_STABLE_FLAG <= 1'b0;
        end else begin
            EXT_OSC_ENABLE <= cfg.ext_osc_enable;
            CLK_MON_ENABLE <= cfg.ext_osc_enable;
            REF_SEL_EXT <= cfg.ext_osc_enable;
            EDGE_FILTER_WIDE <= cfg.edge_filter_wide;
            OSC_EDGE_FILTER_FIELD <= cfg.osc_edge_filter_field;
            OSC_PIN_RESERVE <= cfg.osc_pin_reserve;
            TC_COMP_TRIM <= tc_trim;
            TC_COMP_ACTIVE <= tc_ctrl.active;
            TC_COMP_NEGATIVE <= tc_ctrl.negative;
            TC_COMP_MAG <= tc_ctrl.magnitude;
            LOCK_CLEAR <= cfg_wr_ok;
            PLL_LOCK <= pll_lock;
            OSC_STABLE_FLAG <= osc_stable_flag;
        end
    end
endmodule // ocx_osc_cfg
`default_nettype wire

// [verification/ocx_osc_model.sv]
// Oscillator and PLL stand-in reporting lock and stability
`timescale 1ns/1ps
`default_nettype none
module ocx_osc_model #(
    parameter int LOCK_DLY = 6
) (
    input wire logic clk,
    input wire logic run,
    output logic lock,
    output logic stable
);
    logic [3:0] cnt;
    // Start-up count; stability comes before lock, as on a real oscillator
    always_ff @(posedge clk) begin
        if (!run) cnt <= 4'h0;
        else if (cnt != 4'hf) cnt <= cnt + 4'h1;
    end
    assign lock = (cnt >= 4'(LOCK_DLY));
    assign stable = (cnt >= 4'h3);
endmodule // ocx_osc_model
`default_nettype wire

// [verification/ocx_osc_cfg_properties.sv]
// Checker of the oscillator configuration block at its ports
`timescale 1ns/1ps
`default_nettype none
module ocx_osc_cfg_chk (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic LOCK_CLEAR,
    input wire logic PLL_LOCK,
    input wire logic OSC_STABLE_FLAG,
    input wire logic EXT_OSC_ENABLE,
    input wire logic CLK_MON_ENABLE,
    input wire logic REF_SEL_EXT,
    input wire logic OSC_PIN_RESERVE,
    input wire logic [4:0] TC_COMP_TRIM,
    input wire logic TC_COMP_ACTIVE,
    input wire logic TC_COMP_NEGATIVE,
    input wire logic [3:0] TC_COMP_MAG
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Access phase waiting for its single wait state
    sequence access_s;
        PSEL && PENABLE && !PREADY;
    endsequence
    ready_after_a: assert property (access_s |=> PREADY) else $error("ready late");
    ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
    err_with_ready_a: assert property (PSLVERR |-> PREADY) else $error("error alone");
    osc_select_a: assert property (EXT_OSC_ENABLE == CLK_MON_ENABLE && CLK_MON_ENABLE == REF_SEL_EXT)
        else $error("oscillator controls differ");
    pin_set_a: assert property (EXT_OSC_ENABLE |=> OSC_PIN_RESERVE) else $error("pins not reserved");
    pin_sticky_a: assert property (OSC_PIN_RESERVE |=> OSC_PIN_RESERVE) else $error("pins released");
    tc_off_a: assert property (TC_COMP_ACTIVE == (TC_COMP_TRIM[3:0] != 4'h0)) else $error("tc active");
    tc_dir_a: assert property (TC_COMP_ACTIVE |-> TC_COMP_NEGATIVE == !TC_COMP_TRIM[4])
        else $error("tc direction");
    tc_mag_a: assert property (TC_COMP_MAG == TC_COMP_TRIM[3:0]) else $error("tc magnitude");
    status_clear_a: assert property (LOCK_CLEAR |-> ##[0:1] !PLL_LOCK && !OSC_STABLE_FLAG)
        else $error("status kept");
endmodule // ocx_osc_cfg_chk
bind ocx_osc_cfg ocx_osc_cfg_chk ocx_osc_cfg_chk_i (.*);
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the oscillator configuration block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ocx_pkg::*;
    logic MCLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PLL_LOCK_IN, OSC_STABLE_IN;
    logic EXT_OSC_ENABLE, CLK_MON_ENABLE, REF_SEL_EXT, EDGE_FILTER_WIDE, OSC_PIN_RESERVE;
    logic TC_COMP_ACTIVE, TC_COMP_NEGATIVE, LOCK_CLEAR, PLL_LOCK, OSC_STABLE_FLAG, run;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [3:0] PSTRB, TC_COMP_MAG;
    logic [4:0] OSC_EDGE_FILTER_FIELD, TC_COMP_TRIM;
    logic [33:0] exp_q[$];
    logic [33:0] x;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 69;
    ocx_osc_cfg ocx_osc_cfg_i (.*);
    ocx_osc_model ocx_osc_model_i (.clk(MCLK), .run(run), .lock(PLL_LOCK_IN), .stable(OSC_STABLE_IN));
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One transfer; request held until ready is sampled, then released a cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
        exp_q.push_back(e);
        PSEL <= 1'b1; PWRITE <= w; PADDR <= {a[9:0], 2'b00}; PWDATA <= d;
        @(posedge MCLK) PENABLE <= 1'b1;
        do @(posedge MCLK); while (PREADY !== 1'b1);
        PSEL <= 1'b0; PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 34'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {2'b10, v});
    endtask
    // Monitor: oldest note against each answer; write data is not compared
    always @(posedge MCLK) begin
        if (PREADY === 1'b1) begin
            x = exp_q.pop_front();
            chk({x[33], PSLVERR, x[33] ? PRDATA : 32'h0}, x);
        end
    end
    initial begin
        #100000 fail_count++;
        stop_test();
    end
    initial begin
        {RESET, PSEL, PENABLE, PWRITE, PADDR, PWDATA, run} = {1'b1, 48'h0};
        PSTRB = 4'hf;
        repeat (16) @(posedge MCLK);
        RESET <= 1'b0;
        rd(OCX_OSC_CFG_ADDR, 32'h0);
        rd(OCX_STAT_ADDR, 32'h0);
        wr(OCX_OSC_CFG_ADDR, 32'h80);
        rd(OCX_OSC_CFG_ADDR, 32'h0);
        $display("test 1 done");
        run <= 1'b1;
        wr(OCX_CTRL_ADDR, 32'h2);
        repeat (12) @(posedge MCLK);
        rd(OCX_STAT_ADDR, 32'h3);
        chk(34'({PLL_LOCK, OSC_STABLE_FLAG}), 34'h3);
        // The bench plays software: filter field zero here, external oscillator and wide window on
        wr(OCX_OSC_CFG_ADDR, 32'hc0);
        rd(OCX_OSC_CFG_ADDR, 32'he0);
        rd(OCX_STAT_ADDR, 32'h0);
        chk(34'({PLL_LOCK, OSC_STABLE_FLAG}), 34'h0);
        chk(34'({EXT_OSC_ENABLE, CLK_MON_ENABLE, REF_SEL_EXT, EDGE_FILTER_WIDE}), 34'hf);
        wr(OCX_OSC_CFG_ADDR, 32'h15);
        rd(OCX_OSC_CFG_ADDR, 32'h35);
        chk(34'({EXT_OSC_ENABLE, EDGE_FILTER_WIDE, OSC_PIN_RESERVE, OSC_EDGE_FILTER_FIELD}),
            34'h35);
        $display("test 2 done");
        wr(OCX_CTRL_ADDR, 32'h3);
        wr(OCX_OSC_CFG_ADDR, 32'h80);
        rd(OCX_OSC_CFG_ADDR, 32'h35);
        wr(OCX_CTRL_ADDR, 32'h2);
        // Every trim code, with random junk outside the field; is software's job
        for (int i = 0; i < 32; i++) begin
            wr(OCX_TC_TRIM_ADDR, ($random(seed) & 32'hffff07ff) | (i << 11));
            rd(OCX_TC_TRIM_ADDR, 32'(i << 11));
            chk(34'({TC_COMP_ACTIVE, TC_COMP_NEGATIVE, TC_COMP_MAG}),
                34'({i[3:0] != 0, i[3:0] != 0 && !i[4], i[3:0]}));
        end
        apb(1'b0, 12'h100, 32'h0, {2'b01, 32'h0});
        $display("test 3 done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
